// file: cfg_word_reg.v
// one software-writable configuration word with a reset value and a writable-bit mask
`timescale 1ns/1ps
module cfg_word_reg #(
  parameter [15:0] ADDR = 16'h0000,
  parameter [15:0] RESET_VALUE = 16'h0000,
  parameter [15:0] WRITE_MASK = 16'hffff
) (
  // clock and reset
  input wire i_clk,
  input wire i_rst_b,
  // register port
  input wire [15:0] i_addr,
  input wire [15:0] i_wdata,
  input wire i_wr,
  input wire i_wr_allowed,
  // stored value
  output wire [15:0] o_value
);

  reg [15:0] value_reg;
  wire hit;

  assign hit = i_wr && i_wr_allowed && (i_addr == ADDR);
  assign o_value = value_reg;

  // bits outside the mask never leave zero, so reserved bits read back as zero
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      value_reg <= RESET_VALUE & WRITE_MASK;
    end else if (hit) begin
      value_reg <= i_wdata & WRITE_MASK;
    end
  end

endmodule

// file: depth_filter_regs.v
// configuration and status register bank for the depth camera filter chain and test commands
//
// Operation
// R1: test register bits trigger four test actions
// R2: host writes unlock value before test write
// R3: test write ignored unless unlock directly precedes
// R4: update status reports idle and progress codes
// R5: update status reports outcome and failure codes
// R6: distance median, bilateral, sliding average enables
// R7: distance wiggling and fixed-pattern noise enables
// R8: distance frame averaging and temperature enables
// R9: distance per-pixel offset enable, bit 13
// R10: median iterations in low eight bits
// R11: bilateral range, spatial widths and iterations
// R12: square size squared; sliding window low byte
// R13: frame average count in low eight bits
// R14: amplitude median, bilateral, sliding, frame enables
// R15: amplitude frame average needs distance bit 10
`timescale 1ns/1ps
`include "depth_filter_regs_map.vh"
module depth_filter_regs (
  // clock and reset
  input wire i_clk,
  input wire i_rst_b,
  // register port
  input wire [15:0] i_addr,
  input wire [15:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output wire [15:0] o_rdata,
  // interrupt
  output wire o_irq,
  // update unit progress code
  input wire [7:0] i_update_code,
  // test triggers
  output wire o_watchdog_test,
  output wire o_fake_color_fail,
  output wire o_fake_depth_fail,
  output wire o_force_power_off,
  // distance image processing enables
  output wire o_dist_median_en,
  output wire o_dist_bilateral_en,
  output wire o_dist_sliding_avg_en,
  output wire o_dist_wiggling_en,
  output wire o_dist_fixed_pattern_en,
  output wire o_dist_frame_avg_en,
  output wire o_dist_temperature_en,
  output wire o_dist_offsets_en,
  // amplitude image processing enables
  output wire o_amp_median_en,
  output wire o_amp_bilateral_en,
  output wire o_amp_sliding_avg_en,
  output wire o_amp_frame_avg_en,
  // filter parameters
  output wire [7:0] o_median_iterations,
  output wire [5:0] o_bilateral_range_width,
  output wire [5:0] o_bilateral_spatial_width,
  output wire [3:0] o_bilateral_iterations,
  output wire [5:0] o_bilateral_square_size,
  output wire [11:0] o_bilateral_window_size,
  output wire [7:0] o_sliding_window_size,
  output wire [7:0] o_frame_average_count
);

  // stored words
  wire [15:0] test_trigger_control;
  wire [15:0] distance_filter_enables;
  wire [15:0] median_iteration_count;
  wire [15:0] edge_preserving_params;
  wire [15:0] sliding_average_window;
  wire [15:0] edge_preserving_window;
  wire [15:0] frame_average_depth;
  wire [15:0] amplitude_filter_enables;
  wire [15:0] event_mask;

  // internal state
  reg unlock_reg;
  reg unlock_next;
  reg [7:0] update_status_reg;
  reg [15:0] event_status_reg;
  reg [15:0] event_status_next;
  reg [15:0] rdata_reg;
  reg [15:0] rdata_next;
  reg [11:0] window_size_reg;
  reg amp_frame_avg_reg;
  reg update_failed;
  reg [15:0] event_set;

  wire test_write;
  wire code_changed;

  assign test_write = i_wr && (i_addr == `ADDR_TEST_TRIGGER_CONTROL);
  assign code_changed = (i_update_code != update_status_reg);

  // R2: unlock value arms the test register
  // R3: any other write in between disarms it
  always @* begin
    unlock_next = unlock_reg;
    if (i_wr) begin
      unlock_next = (i_addr == `ADDR_COMMAND_UNLOCK_PASSWORD) && (i_wdata == `UNLOCK_VALUE);
    end
  end

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      unlock_reg <= 1'b0;
    end else begin
      unlock_reg <= unlock_next;
    end
  end

  // R1: test triggers, written only while armed
  // R3: the write strobe is gated by the unlock flag
  cfg_word_reg #(
    .ADDR(`ADDR_TEST_TRIGGER_CONTROL),
    .RESET_VALUE(`RST_TEST_TRIGGER_CONTROL),
    .WRITE_MASK(`MASK_TEST_TRIGGER_CONTROL)
  ) u_test_trigger_control (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_wr_allowed(unlock_reg),
    .o_value(test_trigger_control)
  );

  // R6: distance filter enable word
  cfg_word_reg #(
    .ADDR(`ADDR_DISTANCE_FILTER_ENABLES),
    .RESET_VALUE(`RST_DISTANCE_FILTER_ENABLES),
    .WRITE_MASK(`MASK_DISTANCE_FILTER_ENABLES)
  ) u_distance_filter_enables (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_wr_allowed(1'b1),
    .o_value(distance_filter_enables)
  );

  // R10: median iterations
  cfg_word_reg #(
    .ADDR(`ADDR_MEDIAN_ITERATION_COUNT),
    .RESET_VALUE(`RST_MEDIAN_ITERATION_COUNT),
    .WRITE_MASK(`MASK_LOW_BYTE)
  ) u_median_iteration_count (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_wr_allowed(1'b1),
    .o_value(median_iteration_count)
  );

  // R11: bilateral kernel widths and iterations
  cfg_word_reg #(
    .ADDR(`ADDR_EDGE_PRESERVING_PARAMS),
    .RESET_VALUE(`RST_EDGE_PRESERVING_PARAMS),
    .WRITE_MASK(`MASK_FULL_WORD)
  ) u_edge_preserving_params (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_wr_allowed(1'b1),
    .o_value(edge_preserving_params)
  );

  // R12: sliding average window
  cfg_word_reg #(
    .ADDR(`ADDR_SLIDING_AVERAGE_WINDOW),
    .RESET_VALUE(`RST_SLIDING_AVERAGE_WINDOW),
    .WRITE_MASK(`MASK_LOW_BYTE)
  ) u_sliding_average_window (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_wr_allowed(1'b1),
    .o_value(sliding_average_window)
  );

  // R12: bilateral square size
  cfg_word_reg #(
    .ADDR(`ADDR_EDGE_PRESERVING_WINDOW),
    .RESET_VALUE(`RST_EDGE_PRESERVING_WINDOW),
    .WRITE_MASK(`MASK_SIX_BITS)
  ) u_edge_preserving_window (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_wr_allowed(1'b1),
    .o_value(edge_preserving_window)
  );

  // R13: frames to average
  cfg_word_reg #(
    .ADDR(`ADDR_FRAME_AVERAGE_DEPTH),
    .RESET_VALUE(`RST_FRAME_AVERAGE_DEPTH),
    .WRITE_MASK(`MASK_LOW_BYTE)
  ) u_frame_average_depth (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_wr_allowed(1'b1),
    .o_value(frame_average_depth)
  );

  // R14: amplitude filter enable word
  cfg_word_reg #(
    .ADDR(`ADDR_AMPLITUDE_FILTER_ENABLES),
    .RESET_VALUE(`RST_AMPLITUDE_FILTER_ENABLES),
    .WRITE_MASK(`MASK_AMPLITUDE_FILTER_ENABLES)
  ) u_amplitude_filter_enables (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_wr_allowed(1'b1),
    .o_value(amplitude_filter_enables)
  );

  cfg_word_reg #(
    .ADDR(`ADDR_EVENT_MASK),
    .RESET_VALUE(`RST_EVENT_MASK),
    .WRITE_MASK(`MASK_EVENTS)
  ) u_event_mask (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_wr_allowed(1'b1),
    .o_value(event_mask)
  );

  // R5: codes that end an update unsuccessfully
  always @* begin
    case (i_update_code)
      `UPD_OUT_OF_MEMORY,
      `UPD_CHECKSUM_ERROR,
      `UPD_ERASE_FAILED,
      `UPD_PROGRAM_FAILED,
      `UPD_VERSION_CONFLICT,
      `UPD_WRONG_IDENTIFIER,
      `UPD_INCONSISTENT,
      `UPD_PROTOCOL_VIOLATION: update_failed = 1'b1;
      default: update_failed = 1'b0;
    endcase
  end

  // R4: progress code mirrored from the update unit
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      update_status_reg <= `RST_UPDATE_PROGRESS_STATUS;
    end else begin
      update_status_reg <= i_update_code;
    end
  end

  // update events fire once, on the cycle the code first takes the new value; test events fire on every test write
  always @* begin
    event_set = 16'h0000;
    event_set[`EVT_UPDATE_DONE] = code_changed && (i_update_code == `UPD_SUCCESS);
    event_set[`EVT_UPDATE_FAILED] = code_changed && update_failed;
    event_set[`EVT_TEST_REFUSED] = test_write && !unlock_reg;
    event_set[`EVT_TEST_ACCEPTED] = test_write && unlock_reg;
  end

  // write one to clear; a set in the same cycle wins over the clear
  always @* begin
    event_status_next = event_status_reg;
    if (i_wr && (i_addr == `ADDR_EVENT_STATUS)) begin
      event_status_next = event_status_reg & ~i_wdata;
    end
    event_status_next = (event_status_next | event_set) & `MASK_EVENTS;
  end

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      event_status_reg <= 16'h0000;
    end else begin
      event_status_reg <= event_status_next;
    end
  end

  assign o_irq = |(event_status_reg & event_mask);

  // R12: window is square size squared, registered so the multiplier stays off the output
  // R15: amplitude frame averaging gated by distance frame averaging
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      window_size_reg <= 12'h000;
      amp_frame_avg_reg <= 1'b0;
    end else begin
      window_size_reg <= {6'h00, edge_preserving_window[5:0]} *
                         {6'h00, edge_preserving_window[5:0]};
      amp_frame_avg_reg <= amplitude_filter_enables[`AMP_FRAME_AVG] &
                           distance_filter_enables[`DST_FRAME_AVG];
    end
  end

  // read mux; the password reads zero so the unlock value never leaks back
  always @* begin
    rdata_next = 16'h0000;
    if (i_rd) begin
      case (i_addr)
        `ADDR_TEST_TRIGGER_CONTROL: rdata_next = test_trigger_control;
        `ADDR_UPDATE_PROGRESS_STATUS: rdata_next = {8'h00, update_status_reg};
        `ADDR_DISTANCE_FILTER_ENABLES: rdata_next = distance_filter_enables;
        `ADDR_MEDIAN_ITERATION_COUNT: rdata_next = median_iteration_count;
        `ADDR_EDGE_PRESERVING_PARAMS: rdata_next = edge_preserving_params;
        `ADDR_SLIDING_AVERAGE_WINDOW: rdata_next = sliding_average_window;
        `ADDR_EDGE_PRESERVING_WINDOW: rdata_next = edge_preserving_window;
        `ADDR_FRAME_AVERAGE_DEPTH: rdata_next = frame_average_depth;
        `ADDR_AMPLITUDE_FILTER_ENABLES: rdata_next = amplitude_filter_enables;
        `ADDR_EVENT_STATUS: rdata_next = event_status_reg;
        `ADDR_EVENT_MASK: rdata_next = event_mask;
        default: rdata_next = 16'h0000;
      endcase
    end
  end

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_reg <= 16'h0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign o_rdata = rdata_reg;

  // R1: test trigger outputs
  assign o_watchdog_test = test_trigger_control[`TST_WATCHDOG];
  assign o_fake_color_fail = test_trigger_control[`TST_FAKE_COLOR_FAIL];
  assign o_fake_depth_fail = test_trigger_control[`TST_FAKE_DEPTH_FAIL];
  assign o_force_power_off = test_trigger_control[`TST_FORCE_POWER_OFF];

  // R6: distance filter enables
  assign o_dist_median_en = distance_filter_enables[`DST_MEDIAN];
  assign o_dist_bilateral_en = distance_filter_enables[`DST_BILATERAL];
  assign o_dist_sliding_avg_en = distance_filter_enables[`DST_SLIDING_AVG];
  // R7: distance compensations
  assign o_dist_wiggling_en = distance_filter_enables[`DST_WIGGLING];
  assign o_dist_fixed_pattern_en = distance_filter_enables[`DST_FIXED_PATTERN];
  // R8: frame averaging and temperature
  assign o_dist_frame_avg_en = distance_filter_enables[`DST_FRAME_AVG];
  assign o_dist_temperature_en = distance_filter_enables[`DST_TEMPERATURE];
  // R9: per-pixel offsets
  assign o_dist_offsets_en = distance_filter_enables[`DST_OFFSETS];

  // R14: amplitude filter enables
  assign o_amp_median_en = amplitude_filter_enables[`AMP_MEDIAN];
  assign o_amp_bilateral_en = amplitude_filter_enables[`AMP_BILATERAL];
  assign o_amp_sliding_avg_en = amplitude_filter_enables[`AMP_SLIDING_AVG];
  assign o_amp_frame_avg_en = amp_frame_avg_reg;

  // R10: median field
  assign o_median_iterations = median_iteration_count[7:0];
  // R11: bilateral fields
  assign o_bilateral_range_width = edge_preserving_params[5:0];
  assign o_bilateral_spatial_width = edge_preserving_params[11:6];
  assign o_bilateral_iterations = edge_preserving_params[15:12];
  // R12: window fields
  assign o_bilateral_square_size = edge_preserving_window[5:0];
  assign o_bilateral_window_size = window_size_reg;
  assign o_sliding_window_size = sliding_average_window[7:0];
  // R13: frame count
  assign o_frame_average_count = frame_average_depth[7:0];

endmodule

// file: depth_filter_regs_map.vh
// register offsets, field layouts, reset values and codes of the filter register bank
`ifndef DEPTH_FILTER_REGS_MAP_VH
`define DEPTH_FILTER_REGS_MAP_VH

// register offsets (16-bit register index space)
`define ADDR_COMMAND_UNLOCK_PASSWORD 16'h0022
`define ADDR_TEST_TRIGGER_CONTROL 16'h01c0
`define ADDR_UPDATE_PROGRESS_STATUS 16'h01d1
`define ADDR_DISTANCE_FILTER_ENABLES 16'h01e0
`define ADDR_MEDIAN_ITERATION_COUNT 16'h01e1
`define ADDR_EDGE_PRESERVING_PARAMS 16'h01e4
`define ADDR_SLIDING_AVERAGE_WINDOW 16'h01e5
`define ADDR_EDGE_PRESERVING_WINDOW 16'h01e6
`define ADDR_FRAME_AVERAGE_DEPTH 16'h01e7
`define ADDR_AMPLITUDE_FILTER_ENABLES 16'h01e9
`define ADDR_EVENT_STATUS 16'h01f0
`define ADDR_EVENT_MASK 16'h01f1

// reset values
`define RST_TEST_TRIGGER_CONTROL 16'h0000
`define RST_UPDATE_PROGRESS_STATUS 8'h00
`define RST_DISTANCE_FILTER_ENABLES 16'h28c0
`define RST_MEDIAN_ITERATION_COUNT 16'h0001
`define RST_EDGE_PRESERVING_PARAMS 16'h13de
`define RST_SLIDING_AVERAGE_WINDOW 16'h0005
`define RST_EDGE_PRESERVING_WINDOW 16'h0003
`define RST_FRAME_AVERAGE_DEPTH 16'h0002
`define RST_AMPLITUDE_FILTER_ENABLES 16'h0000
`define RST_EVENT_MASK 16'h0000

// implemented bits per register; the others read as zero
`define MASK_TEST_TRIGGER_CONTROL 16'h001e
`define MASK_DISTANCE_FILTER_ENABLES 16'h2cd9
`define MASK_LOW_BYTE 16'h00ff
`define MASK_FULL_WORD 16'hffff
`define MASK_SIX_BITS 16'h003f
`define MASK_AMPLITUDE_FILTER_ENABLES 16'h000f
`define MASK_EVENTS 16'h000f

// unlock value for the test trigger register
`define UNLOCK_VALUE 16'h5e6b

// test trigger bits
`define TST_WATCHDOG 1
`define TST_FAKE_COLOR_FAIL 2
`define TST_FAKE_DEPTH_FAIL 3
`define TST_FORCE_POWER_OFF 4

// distance filter enable bits
`define DST_MEDIAN 0
`define DST_BILATERAL 3
`define DST_SLIDING_AVG 4
`define DST_WIGGLING 6
`define DST_FIXED_PATTERN 7
`define DST_FRAME_AVG 10
`define DST_TEMPERATURE 11
`define DST_OFFSETS 13

// amplitude filter enable bits
`define AMP_MEDIAN 0
`define AMP_BILATERAL 1
`define AMP_SLIDING_AVG 2
`define AMP_FRAME_AVG 3

// update progress codes
`define UPD_IDLE 8'h00
`define UPD_OUT_OF_MEMORY 8'h03
`define UPD_CHECKSUM_ERROR 8'h06
`define UPD_ERASING 8'h08
`define UPD_PROGRAMMING 8'h09
`define UPD_ERASE_FAILED 8'h0b
`define UPD_PROGRAM_FAILED 8'h0c
`define UPD_SUCCESS 8'h0e
`define UPD_VERSION_CONFLICT 8'h10
`define UPD_WRONG_IDENTIFIER 8'h12
`define UPD_INCONSISTENT 8'h14
`define UPD_IN_PROGRESS 8'h15
`define UPD_PROTOCOL_VIOLATION 8'hff

// event bits
`define EVT_UPDATE_DONE 0
`define EVT_UPDATE_FAILED 1
`define EVT_TEST_REFUSED 2
`define EVT_TEST_ACCEPTED 3

`endif

// file: depth_filter_regs_properties.sv
// port-level assertions for the filter register bank
`timescale 1ns/1ps
`include "depth_filter_regs_map.vh"
module depth_filter_regs_properties (
  // clock and reset
  input wire i_clk,
  input wire i_rst_b,
  // register port
  input wire [15:0] i_addr,
  input wire [15:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [15:0] o_rdata,
  input wire [7:0] i_update_code,
  // watched outputs
  input wire o_watchdog_test,
  input wire o_fake_color_fail,
  input wire o_fake_depth_fail,
  input wire o_force_power_off,
  input wire o_dist_median_en,
  input wire o_dist_frame_avg_en,
  input wire o_dist_offsets_en,
  input wire o_amp_frame_avg_en,
  input wire [7:0] o_median_iterations,
  input wire [5:0] o_bilateral_range_width,
  input wire [3:0] o_bilateral_iterations,
  input wire [5:0] o_bilateral_square_size,
  input wire [11:0] o_bilateral_window_size
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  reg arm_reg;
  wire wr_test = i_wr && i_addr == `ADDR_TEST_TRIGGER_CONTROL;
  wire [3:0] tst = {o_force_power_off, o_fake_depth_fail, o_fake_color_fail, o_watchdog_test};
  // reads between unlock and test write keep the arm, any write replaces it
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      arm_reg <= 1'b0;
    end else if (i_wr) begin
      arm_reg <= i_addr == `ADDR_COMMAND_UNLOCK_PASSWORD && i_wdata == `UNLOCK_VALUE;
    end
  end
  property p_test_ok;
    wr_test && arm_reg |=> tst == $past(i_wdata[4:1]);
  endproperty
  a_test_ok: assert property (p_test_ok) else $error("armed test write not taken");
  property p_test_refused;
    wr_test && !arm_reg |=> $stable(tst);
  endproperty
  a_test_refused: assert property (p_test_refused) else $error("unarmed test write took effect");
  property p_dist_en;
    i_wr && i_addr == `ADDR_DISTANCE_FILTER_ENABLES
      |=> {o_dist_offsets_en, o_dist_median_en} == {$past(i_wdata[13]), $past(i_wdata[0])};
  endproperty
  a_dist_en: assert property (p_dist_en) else $error("distance enable bits wrong");
  property p_dist_frame;
    i_wr && i_addr == `ADDR_DISTANCE_FILTER_ENABLES |=> o_dist_frame_avg_en == $past(i_wdata[10]);
  endproperty
  a_dist_frame: assert property (p_dist_frame) else $error("frame average enable wrong");
  property p_median;
    i_wr && i_addr == `ADDR_MEDIAN_ITERATION_COUNT |=> o_median_iterations == $past(i_wdata[7:0]);
  endproperty
  a_median: assert property (p_median) else $error("median iterations wrong");
  property p_bilateral;
    i_wr && i_addr == `ADDR_EDGE_PRESERVING_PARAMS
      |=> {o_bilateral_iterations, o_bilateral_range_width} == {$past(i_wdata[15:12]), $past(i_wdata[5:0])};
  endproperty
  a_bilateral: assert property (p_bilateral) else $error("bilateral fields wrong");
  property p_window;
    1'b1 |=> o_bilateral_window_size == $past(o_bilateral_square_size) * $past(o_bilateral_square_size);
  endproperty
  a_window: assert property (p_window) else $error("window is not square size squared");
  property p_amp_gate;
    o_amp_frame_avg_en |-> $past(o_dist_frame_avg_en);
  endproperty
  a_amp_gate: assert property (p_amp_gate) else $error("amplitude frame average without bit 10");
  property p_update;
    i_rd && i_addr == `ADDR_UPDATE_PROGRESS_STATUS && $stable(i_update_code)
      |=> o_rdata == {8'h00, $past(i_update_code, 2)};
  endproperty
  a_update: assert property (p_update) else $error("update status read wrong");
  c_test_ok: cover property (wr_test && arm_reg);
  c_test_refused: cover property (wr_test && !arm_reg);
  c_amp_gate: cover property (o_amp_frame_avg_en);
endmodule
bind depth_filter_regs depth_filter_regs_properties u_props (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_update_code(i_update_code),
  .o_watchdog_test(o_watchdog_test), .o_fake_color_fail(o_fake_color_fail),
  .o_fake_depth_fail(o_fake_depth_fail), .o_force_power_off(o_force_power_off),
  .o_dist_median_en(o_dist_median_en), .o_dist_frame_avg_en(o_dist_frame_avg_en),
  .o_dist_offsets_en(o_dist_offsets_en), .o_amp_frame_avg_en(o_amp_frame_avg_en),
  .o_median_iterations(o_median_iterations), .o_bilateral_range_width(o_bilateral_range_width),
  .o_bilateral_iterations(o_bilateral_iterations),
  .o_bilateral_square_size(o_bilateral_square_size),
  .o_bilateral_window_size(o_bilateral_window_size));

// file: host_model.sv
// register bus master standing in for the host on the control link
`timescale 1ns/1ps
`include "depth_filter_regs_map.vh"
module host_model (
  // clock
  input wire i_clk,
  // register port towards the bank
  output reg [15:0] o_addr,
  output reg [15:0] o_wdata,
  output reg o_wr,
  output reg o_rd,
  input wire [15:0] i_rdata
);
  initial begin
    o_addr = 16'h0000;
    o_wdata = 16'h0000;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // two clocks per access, so a strobe never rises in the step that drops it
  // return 1 ns past the edge, so outputs launched at that edge have settled
  task wr(input [15:0] a, input [15:0] d);
    begin
      o_addr <= a;
      o_wdata <= d;
      o_wr <= 1'b1;
      @(posedge i_clk);
      o_wr <= 1'b0;
      o_wdata <= ~d;
      @(posedge i_clk);
      #1;
    end
  endtask
  task rd(input [15:0] a, output [15:0] d);
    begin
      o_addr <= a;
      o_rd <= 1'b1;
      @(posedge i_clk);
      o_rd <= 1'b0;
      o_addr <= ~a;
      #1;
      d = i_rdata;
      @(posedge i_clk);
      #1;
    end
  endtask
  task unlock;
    wr(`ADDR_COMMAND_UNLOCK_PASSWORD, `UNLOCK_VALUE);
  endtask
endmodule

// file: tb_top.sv
// self-checking bench for the filter register bank
`timescale 1ns/1ps
`include "depth_filter_regs_map.vh"
module tb_top;
  reg i_clk = 1'b0;
  reg i_rst_b = 1'b0;
  reg [7:0] i_update_code = 8'h00;
  wire [15:0] addr, wdata, rdata;
  wire wr, rd, irq;
  wire [3:0] tst, amp, b_it;
  wire [7:0] dst, med, slide, frames;
  wire [5:0] rng, spa, sq;
  wire [11:0] win;
  int error_cnt = 0;
  int n_compared = 0;
  int i;
  logic [15:0] ra [11] = '{16'h01c0, 16'h01d1, 16'h01e0, 16'h01e1, 16'h01e4, 16'h01e5,
    16'h01e6, 16'h01e7, 16'h01e9, 16'h0022, 16'h01e2};
  logic [15:0] rv [11] = '{16'h0000, 16'h0000, 16'h28c0, 16'h0001, 16'h13de, 16'h0005,
    16'h0003, 16'h0002, 16'h0000, 16'h0000, 16'h0000};
  logic [15:0] wm [7] = '{16'h2cd9, 16'h00ff, 16'hffff, 16'h00ff, 16'h003f, 16'h00ff, 16'h000f};
  logic [7:0] codes [13] = '{8'h00, 8'h03, 8'h06, 8'h08, 8'h09, 8'h0b, 8'h0c, 8'h0e, 8'h10,
    8'h12, 8'h14, 8'h15, 8'hff};
  host_model host (.i_clk(i_clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd),
    .i_rdata(rdata));
  depth_filter_regs DUT (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq), .i_update_code(i_update_code),
    .o_watchdog_test(tst[0]), .o_fake_color_fail(tst[1]), .o_fake_depth_fail(tst[2]),
    .o_force_power_off(tst[3]), .o_dist_median_en(dst[0]), .o_dist_bilateral_en(dst[1]),
    .o_dist_sliding_avg_en(dst[2]), .o_dist_wiggling_en(dst[3]),
    .o_dist_fixed_pattern_en(dst[4]), .o_dist_frame_avg_en(dst[5]),
    .o_dist_temperature_en(dst[6]), .o_dist_offsets_en(dst[7]), .o_amp_median_en(amp[0]),
    .o_amp_bilateral_en(amp[1]), .o_amp_sliding_avg_en(amp[2]), .o_amp_frame_avg_en(amp[3]),
    .o_median_iterations(med), .o_bilateral_range_width(rng), .o_bilateral_spatial_width(spa),
    .o_bilateral_iterations(b_it), .o_bilateral_square_size(sq), .o_bilateral_window_size(win),
    .o_sliding_window_size(slide), .o_frame_average_count(frames));
  initial begin
    forever #2 i_clk = ~i_clk;
  end
  task stop_test;
    begin
      if (error_cnt == 0 && n_compared > 0) begin
        $display("[ PASS ]");
      end else begin
        $display("[ FAIL ]");
      end
      $finish;
    end
  endtask
  task chk(input string name, input [15:0] exp, input [15:0] got);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[ERR] %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task rchk(input [15:0] a, input [15:0] exp);
    reg [15:0] d;
    begin
      host.rd(a, d);
      chk($sformatf("read %h", a), exp, d);
    end
  endtask
  initial begin
    #100000;
    error_cnt = error_cnt + 1;
    stop_test;
  end
  initial begin
    repeat (4) @(posedge i_clk);
    i_rst_b <= 1'b1;
    @(posedge i_clk);
    for (i = 0; i < 11; i = i + 1) begin
      rchk(ra[i], rv[i]);
    end
    chk("window", 16'h0009, {4'h0, win});
    chk("dist", 16'h00d8, {8'h00, dst});
    // ones everywhere, unimplemented bits must read zero
    for (i = 0; i < 7; i = i + 1) begin
      host.wr(ra[i + 2], 16'hffff);
      rchk(ra[i + 2], wm[i]);
    end
    host.wr(`ADDR_UPDATE_PROGRESS_STATUS, 16'hffff);
    rchk(`ADDR_UPDATE_PROGRESS_STATUS, 16'h0000);
    chk("dist", 16'h00ff, {8'h00, dst});
    chk("amp", 16'h000f, {12'h000, amp});
    chk("window", 16'h0f81, {4'h0, win});
    chk("fields", 16'hffff, {b_it, spa, rng});
    chk("bytes", 16'hffff, {med, slide});
    chk("frames", 16'h00ff, {8'h00, frames});
    host.wr(`ADDR_DISTANCE_FILTER_ENABLES, 16'h0489);
    chk("dist", 16'h0033, {8'h00, dst});
    chk("amp", 16'h000f, {12'h000, amp});
    host.wr(`ADDR_DISTANCE_FILTER_ENABLES, 16'h0000);
    chk("amp", 16'h0007, {12'h000, amp});
    rchk(`ADDR_AMPLITUDE_FILTER_ENABLES, 16'h000f);
    host.wr(`ADDR_AMPLITUDE_FILTER_ENABLES, 16'h0005);
    chk("amp", 16'h0005, {12'h000, amp});
    host.wr(`ADDR_EDGE_PRESERVING_PARAMS, 16'ha5c3);
    chk("fields", 16'ha5c3, {b_it, spa, rng});
    host.wr(`ADDR_EDGE_PRESERVING_WINDOW, 16'h0005);
    host.wr(`ADDR_MEDIAN_ITERATION_COUNT, 16'h0007);
    chk("window", 16'h0019, {4'h0, win});
    chk("square", 16'h0005, {10'h000, sq});
    chk("median", 16'h0007, {8'h00, med});
    // test triggers: refused without arm, wrong key, or another write in between
    host.wr(`ADDR_EVENT_STATUS, 16'h000f);
    host.wr(`ADDR_TEST_TRIGGER_CONTROL, 16'h001e);
    host.wr(`ADDR_COMMAND_UNLOCK_PASSWORD, 16'h5e6a);
    host.wr(`ADDR_TEST_TRIGGER_CONTROL, 16'h001e);
    host.unlock;
    host.wr(`ADDR_MEDIAN_ITERATION_COUNT, 16'h0007);
    host.wr(`ADDR_TEST_TRIGGER_CONTROL, 16'h001e);
    rchk(`ADDR_TEST_TRIGGER_CONTROL, 16'h0000);
    chk("test", 16'h0000, {12'h000, tst});
    rchk(`ADDR_EVENT_STATUS, 16'h0004);
    host.unlock;
    rchk(`ADDR_MEDIAN_ITERATION_COUNT, 16'h0007);
    host.wr(`ADDR_TEST_TRIGGER_CONTROL, 16'h001e);
    rchk(`ADDR_TEST_TRIGGER_CONTROL, 16'h001e);
    chk("test", 16'h000f, {12'h000, tst});
    host.unlock;
    host.wr(`ADDR_TEST_TRIGGER_CONTROL, 16'h000a);
    chk("test", 16'h0005, {12'h000, tst});
    rchk(`ADDR_EVENT_STATUS, 16'h000c);
    // every progress code, with the failure event unmasked
    host.wr(`ADDR_EVENT_STATUS, 16'h000f);
    host.wr(`ADDR_EVENT_MASK, 16'h0002);
    for (i = 0; i < 13; i = i + 1) begin
      i_update_code <= codes[i];
      @(posedge i_clk);
      rchk(`ADDR_UPDATE_PROGRESS_STATUS, {8'h00, codes[i]});
    end
    rchk(`ADDR_EVENT_STATUS, 16'h0003);
    chk("irq", 16'h0001, {15'h0000, irq});
    host.wr(`ADDR_EVENT_MASK, 16'h0000);
    chk("irq", 16'h0000, {15'h0000, irq});
    host.wr(`ADDR_EVENT_MASK, 16'h0001);
    chk("irq", 16'h0001, {15'h0000, irq});
    rchk(`ADDR_EVENT_MASK, 16'h0001);
    host.wr(`ADDR_EVENT_STATUS, 16'h0003);
    rchk(`ADDR_EVENT_STATUS, 16'h0000);
    chk("irq", 16'h0000, {15'h0000, irq});
    stop_test;
  end
endmodule
